// *** hw/tcru_params.svh ***
`ifndef TCRU_PARAMS_SVH
`define TCRU_PARAMS_SVH

// Register indices; byte address is four times the index
`define TCRU_IDX_TIMER_CONTROL 10'h0c8
`define TCRU_IDX_TIMER_MODE_CONTROL 10'h0c9
`define TCRU_IDX_CAPTURE_RELOAD_LOW 10'h0ca
`define TCRU_IDX_CAPTURE_RELOAD_HIGH 10'h0cb
`define TCRU_IDX_COUNT_LOW 10'h0cc
`define TCRU_IDX_COUNT_HIGH 10'h0cd
`define TCRU_IDX_TICK_CONFIG 10'h0d0
`define TCRU_IDX_IRQ_STATUS 10'h0d1
`define TCRU_IDX_IRQ_MASK 10'h0d2

// timer_control fields
`define TCRU_CTL_OVERFLOW_FLAG 7
`define TCRU_CTL_EXTERNAL_FLAG 6
`define TCRU_CTL_RX_BAUD_SEL 5
`define TCRU_CTL_TX_BAUD_SEL 4
`define TCRU_CTL_TRIGGER_ENABLE 3
`define TCRU_CTL_RUN_CONTROL 2
`define TCRU_CTL_COUNTER_TIMER_SELECT 1
`define TCRU_CTL_CAPTURE_RELOAD_SELECT 0

// timer_mode_control fields
`define TCRU_MOD_AUTO_CLEAR_MSB 7
`define TCRU_MOD_AUTO_CLEAR_LSB 4
`define TCRU_MOD_CAPTURE_AUTO_RESET 3
`define TCRU_MOD_CLOCK_OUT_ENABLE 1
`define TCRU_MOD_DOWN_COUNT_ENABLE 0
`define TCRU_MOD_WRITE_MASK 8'hfb

// Interrupt status bits
`define TCRU_IRQ_OVERFLOW 0
`define TCRU_IRQ_EXTERNAL 1

// Reset values and count top
`define TCRU_RST_BYTE 8'h00
`define TCRU_RST_WORD 16'h0000
`define TCRU_COUNT_TOP 16'hffff

// Core clocks per count tick
`define TCRU_DIV_SLOW 4'd12
`define TCRU_DIV_FAST 4'd4
`define TCRU_DIV_BAUD 4'd2

`endif

// *** hw/tcru_pkg.sv ***
package tcru_pkg;

  typedef enum logic [1:0] {
    TCRU_MODE_CAPTURE,
    TCRU_MODE_RELOAD,
    TCRU_MODE_UPDOWN,
    TCRU_MODE_BAUD
  } tcru_mode_t;

  typedef struct packed {
    logic stage1;
    logic stage2;
    logic stage3;
    logic fall;
  } tcru_sync_t;

  typedef struct packed {
    logic [3:0] phase;
    logic tick_slow;
    logic tick_fast;
    logic tick_baud;
  } tcru_div_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] modc;
    logic [15:0] cap;
    logic [15:0] cnt;
    logic tick_sel;
    logic [1:0] irq_st;
    logic [1:0] irq_msk;
    logic clk_out;
    logic clk_out_oe_n;
    logic rx_tick;
    logic tx_tick;
    logic [3:0] ext_clr;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } tcru_state_t;

endpackage

// *** hw/tcru_edge_sync.sv ***
`timescale 1ns/1ps
module tcru_edge_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin,
  output logic level,
  output logic fall
);
  import tcru_pkg::*;

  tcru_sync_t st_reg;
  tcru_sync_t st_next;

  // Only stage2 reads stage1; edge uses the settled stages
  always_comb begin
    st_next = st_reg;
    st_next.stage1 = pin;
    st_next.stage2 = st_reg.stage1;
    st_next.stage3 = st_reg.stage2;
    st_next.fall = st_reg.stage3 & ~st_reg.stage2;
  end

  // Reset high so an idle-high pin gives no false edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '{stage1: 1'b1, stage2: 1'b1, stage3: 1'b1, fall: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign level = st_reg.stage2;
  assign fall = st_reg.fall;
endmodule

// *** hw/tcru_tick_gen.sv ***
`timescale 1ns/1ps
`include "tcru_params.svh"
module tcru_tick_gen (
  input wire logic pclk,
  input wire logic presetn,
  output logic tick_slow,
  output logic tick_fast,
  output logic tick_baud
);
  import tcru_pkg::*;

  tcru_div_t st_reg;
  tcru_div_t st_next;

  // One phase counter serves all rates since 12 is a multiple of 4 and 2
  always_comb begin
    st_next = st_reg;
    st_next.phase = (st_reg.phase == 4'(`TCRU_DIV_SLOW - 4'd1)) ? 4'd0 : 4'(st_reg.phase + 4'd1);
    st_next.tick_slow = (st_reg.phase == 4'(`TCRU_DIV_SLOW - 4'd1));
    st_next.tick_fast = (st_reg.phase[1:0] == 2'(`TCRU_DIV_FAST - 4'd1));
    st_next.tick_baud = (st_reg.phase[0] == 1'(`TCRU_DIV_BAUD - 4'd1));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick_slow = st_reg.tick_slow;
  assign tick_fast = st_reg.tick_fast;
  assign tick_baud = st_reg.tick_baud;
endmodule

// *** hw/tcru_top.sv ***
// Behaviour
// [R1] Overflow flag sets on 16-bit wrap, or down-count match with capture value; software sets/clears.
// [R2] Overflow flag never sets while either baud select bit is one.
// [R3] External flag sets on trigger falling edge outside up/down mode, or toggles on up/down overflow; software clears.
// [R4] Timer interrupt raised on software write of external flag one or trigger edge.
// [R5] Serial receive timing from timer 1 overflow, or this timer's when rx select set.
// [R6] Serial transmit timing from timer 1 overflow, or this timer's when tx select set.
// [R7] Any baud select forces baud mode: reload on every overflow, ignore capture/reload select.
// [R8] Trigger edges ignored unless trigger enable; then edges capture or reload in capture and reload modes only.
// [R9] Counting only while run control is one; clearing it holds the count.
// [R10] Timer mode counts internal ticks at selected speed; counter mode counts count pin falls.
// [R11] Baud mode advances once every two core clocks regardless of counter/timer select.
// [R12] Reload mode reloads on overflow, and on trigger edge when trigger enable set.
// [R13] Capture mode with trigger enable copies count into capture registers on trigger edge.
// [R14] Capture auto-reset clears count after the count has been captured.
// [R15] Clock-out driven only while clock-out enable is set.
// [R16] Up/down auto-reload direction comes from down-count enable and trigger pin level.
// [R17] Capture registers hold captured count, or the 16-bit reload value.
// [R18] Auto-clear bits 7..4 clear external interrupt 5..2 flags on service entry.
// [R19] Clock-out pin toggles on each overflow while enabled.
`timescale 1ns/1ps
`include "tcru_params.svh"
module tcru_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic trigger_pin,
  input wire logic count_input_pin,
  input wire logic timer1_overflow,
  input wire logic [3:0] ext_isr_entry,
  output logic [3:0] ext_flag_auto_clear,
  output logic rx_baud_tick,
  output logic tx_baud_tick,
  output logic clock_out_pin,
  output logic clock_out_oe_n,
  output logic irq
);
  import tcru_pkg::*;

  tcru_state_t st_reg;
  tcru_state_t st_next;

  logic trig_level;
  logic trig_fall;
  logic cnt_pin_fall;
  logic tick_slow;
  logic tick_fast;
  logic tick_baud;

  tcru_edge_sync u_trig_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(trigger_pin),
    .level(trig_level),
    .fall(trig_fall)
  );

  tcru_edge_sync u_count_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(count_input_pin),
    .level(),
    .fall(cnt_pin_fall)
  );

  tcru_tick_gen u_tick_gen (
    .pclk(pclk),
    .presetn(presetn),
    .tick_slow(tick_slow),
    .tick_fast(tick_fast),
    .tick_baud(tick_baud)
  );

  function automatic logic reg_hit(input logic [11:0] addr, input logic [9:0] idx);
    reg_hit = (addr[11:2] == idx);
  endfunction

  function automatic logic reg_mapped(input logic [11:0] addr);
    reg_mapped = reg_hit(addr, `TCRU_IDX_TIMER_CONTROL) | reg_hit(addr, `TCRU_IDX_TIMER_MODE_CONTROL) |
                 reg_hit(addr, `TCRU_IDX_CAPTURE_RELOAD_LOW) | reg_hit(addr, `TCRU_IDX_CAPTURE_RELOAD_HIGH) |
                 reg_hit(addr, `TCRU_IDX_COUNT_LOW) | reg_hit(addr, `TCRU_IDX_COUNT_HIGH) |
                 reg_hit(addr, `TCRU_IDX_TICK_CONFIG) | reg_hit(addr, `TCRU_IDX_IRQ_STATUS) |
                 reg_hit(addr, `TCRU_IDX_IRQ_MASK);
  endfunction

  tcru_mode_t mode;
  logic baud_sel;
  logic step;
  logic trig_evt;
  logic ovf;
  logic tf_set;
  logic exf_set;
  logic exf_tog;
  logic ext_evt;
  logic wr;
  logic wr_ctrl;
  logic [7:0] rd_byte;
  logic tf_base;
  logic exf_base;
  logic [1:0] irq_base;
  logic [1:0] irq_evt;

  always_comb begin
    st_next = st_reg;
    ovf = 1'b0;
    exf_set = 1'b0;
    exf_tog = 1'b0;
    rd_byte = 8'h00;

    baud_sel = st_reg.ctrl[`TCRU_CTL_RX_BAUD_SEL] | st_reg.ctrl[`TCRU_CTL_TX_BAUD_SEL];
    if (baud_sel) begin
      mode = TCRU_MODE_BAUD; // [R7]
    end else if (st_reg.ctrl[`TCRU_CTL_CAPTURE_RELOAD_SELECT]) begin
      mode = TCRU_MODE_CAPTURE;
    end else if (st_reg.modc[`TCRU_MOD_DOWN_COUNT_ENABLE]) begin
      mode = TCRU_MODE_UPDOWN;
    end else begin
      mode = TCRU_MODE_RELOAD;
    end

    // Count source and gating
    if (!st_reg.ctrl[`TCRU_CTL_RUN_CONTROL]) begin
      step = 1'b0; // [R9]
    end else if (baud_sel) begin
      step = tick_baud; // [R11]
    end else if (st_reg.ctrl[`TCRU_CTL_COUNTER_TIMER_SELECT]) begin
      step = cnt_pin_fall; // [R10]
    end else begin
      step = st_reg.tick_sel ? tick_fast : tick_slow; // [R10]
    end

    trig_evt = st_reg.ctrl[`TCRU_CTL_TRIGGER_ENABLE] & trig_fall; // [R8]

    case (mode)
      TCRU_MODE_BAUD: begin
        if (step) begin
          if (st_reg.cnt == `TCRU_COUNT_TOP) begin
            st_next.cnt = st_reg.cap; // [R7]
            ovf = 1'b1;
          end else begin
            st_next.cnt = 16'(st_reg.cnt + 16'h0001);
          end
        end
        // Edge only flags here; no capture or reload while making baud clocks
        exf_set = trig_evt; // [R8]
      end
      TCRU_MODE_CAPTURE: begin
        if (step) begin
          st_next.cnt = 16'(st_reg.cnt + 16'h0001);
          ovf = (st_reg.cnt == `TCRU_COUNT_TOP);
        end
        if (trig_evt) begin
          st_next.cap = st_reg.cnt; // [R13] [R17]
          exf_set = 1'b1; // [R3]
          if (st_reg.modc[`TCRU_MOD_CAPTURE_AUTO_RESET]) begin
            st_next.cnt = `TCRU_RST_WORD; // [R14]
          end
        end
      end
      TCRU_MODE_RELOAD: begin
        if (step) begin
          if (st_reg.cnt == `TCRU_COUNT_TOP) begin
            st_next.cnt = st_reg.cap; // [R12] [R17]
            ovf = 1'b1;
          end else begin
            st_next.cnt = 16'(st_reg.cnt + 16'h0001);
          end
        end
        if (trig_evt) begin
          st_next.cnt = st_reg.cap; // [R12]
          exf_set = 1'b1; // [R3]
        end
      end
      TCRU_MODE_UPDOWN: begin
        // Trigger level high counts up, low counts down
        if (step) begin
          if (trig_level) begin // [R16]
            if (st_reg.cnt == `TCRU_COUNT_TOP) begin
              st_next.cnt = st_reg.cap;
              ovf = 1'b1;
              exf_tog = 1'b1; // [R3]
            end else begin
              st_next.cnt = 16'(st_reg.cnt + 16'h0001);
            end
          end else begin
            if (st_reg.cnt == st_reg.cap) begin
              st_next.cnt = `TCRU_COUNT_TOP; // [R1]
              ovf = 1'b1;
              exf_tog = 1'b1; // [R3]
            end else begin
              st_next.cnt = 16'(st_reg.cnt - 16'h0001);
            end
          end
        end
      end
      default: begin
        st_next.cnt = st_reg.cnt;
      end
    endcase

    tf_set = ovf & ~baud_sel; // [R1] [R2]

    // APB: registered pready gives exactly one access cycle
    st_next.pready = psel & ~penable;
    wr = psel & penable & pwrite & st_reg.pready;
    wr_ctrl = wr & reg_hit(paddr, `TCRU_IDX_TIMER_CONTROL);

    if (wr_ctrl) begin
      st_next.ctrl = pwdata[7:0];
    end
    if (wr & reg_hit(paddr, `TCRU_IDX_TIMER_MODE_CONTROL)) begin
      st_next.modc = pwdata[7:0] & `TCRU_MOD_WRITE_MASK;
    end
    if (wr & reg_hit(paddr, `TCRU_IDX_CAPTURE_RELOAD_LOW)) begin
      st_next.cap[7:0] = pwdata[7:0]; // [R17]
    end
    if (wr & reg_hit(paddr, `TCRU_IDX_CAPTURE_RELOAD_HIGH)) begin
      st_next.cap[15:8] = pwdata[7:0]; // [R17]
    end
    // Software count writes win over the same-cycle hardware step
    if (wr & reg_hit(paddr, `TCRU_IDX_COUNT_LOW)) begin
      st_next.cnt[7:0] = pwdata[7:0];
    end
    if (wr & reg_hit(paddr, `TCRU_IDX_COUNT_HIGH)) begin
      st_next.cnt[15:8] = pwdata[7:0];
    end
    if (wr & reg_hit(paddr, `TCRU_IDX_TICK_CONFIG)) begin
      st_next.tick_sel = pwdata[0];
    end
    if (wr & reg_hit(paddr, `TCRU_IDX_IRQ_MASK)) begin
      st_next.irq_msk = pwdata[1:0];
    end

    // Flags: hardware set wins over a software clear in the same cycle
    tf_base = wr_ctrl ? pwdata[`TCRU_CTL_OVERFLOW_FLAG] : st_reg.ctrl[`TCRU_CTL_OVERFLOW_FLAG];
    exf_base = wr_ctrl ? pwdata[`TCRU_CTL_EXTERNAL_FLAG] : st_reg.ctrl[`TCRU_CTL_EXTERNAL_FLAG];
    st_next.ctrl[`TCRU_CTL_OVERFLOW_FLAG] = tf_base | tf_set; // [R1]
    st_next.ctrl[`TCRU_CTL_EXTERNAL_FLAG] = (exf_base ^ exf_tog) | exf_set; // [R3]

    ext_evt = exf_set | trig_fall & st_reg.ctrl[`TCRU_CTL_TRIGGER_ENABLE] |
              (wr_ctrl & pwdata[`TCRU_CTL_EXTERNAL_FLAG]); // [R4]
    irq_evt = {ext_evt, tf_set};
    irq_base = (wr & reg_hit(paddr, `TCRU_IDX_IRQ_STATUS)) ? (st_reg.irq_st & ~pwdata[1:0]) : st_reg.irq_st;
    st_next.irq_st = irq_base | irq_evt;
    st_next.irq = |(st_next.irq_st & st_next.irq_msk); // [R4]

    // Serial port timing selection
    st_next.rx_tick = st_reg.ctrl[`TCRU_CTL_RX_BAUD_SEL] ? ovf : timer1_overflow; // [R5]
    st_next.tx_tick = st_reg.ctrl[`TCRU_CTL_TX_BAUD_SEL] ? ovf : timer1_overflow; // [R6]

    // Clock-out: parked low while disabled so re-enable starts from a known phase
    if (!st_reg.modc[`TCRU_MOD_CLOCK_OUT_ENABLE]) begin
      st_next.clk_out = 1'b0; // [R15]
    end else if (ovf) begin
      st_next.clk_out = ~st_reg.clk_out; // [R19]
    end
    st_next.clk_out_oe_n = ~st_reg.modc[`TCRU_MOD_CLOCK_OUT_ENABLE]; // [R15]

    st_next.ext_clr = st_reg.modc[`TCRU_MOD_AUTO_CLEAR_MSB:`TCRU_MOD_AUTO_CLEAR_LSB] & ext_isr_entry; // [R18]

    // Read data latched in the setup cycle
    if (reg_hit(paddr, `TCRU_IDX_TIMER_CONTROL)) begin
      rd_byte = st_reg.ctrl;
    end else if (reg_hit(paddr, `TCRU_IDX_TIMER_MODE_CONTROL)) begin
      rd_byte = st_reg.modc;
    end else if (reg_hit(paddr, `TCRU_IDX_CAPTURE_RELOAD_LOW)) begin
      rd_byte = st_reg.cap[7:0];
    end else if (reg_hit(paddr, `TCRU_IDX_CAPTURE_RELOAD_HIGH)) begin
      rd_byte = st_reg.cap[15:8];
    end else if (reg_hit(paddr, `TCRU_IDX_COUNT_LOW)) begin
      rd_byte = st_reg.cnt[7:0];
    end else if (reg_hit(paddr, `TCRU_IDX_COUNT_HIGH)) begin
      rd_byte = st_reg.cnt[15:8];
    end else if (reg_hit(paddr, `TCRU_IDX_TICK_CONFIG)) begin
      rd_byte = {7'h00, st_reg.tick_sel};
    end else if (reg_hit(paddr, `TCRU_IDX_IRQ_STATUS)) begin
      rd_byte = {6'h00, st_reg.irq_st};
    end else if (reg_hit(paddr, `TCRU_IDX_IRQ_MASK)) begin
      rd_byte = {6'h00, st_reg.irq_msk};
    end
    if (psel & ~penable) begin
      st_next.prdata = {24'h000000, rd_byte};
      st_next.pslverr = ~reg_mapped(paddr);
    end else if (!psel) begin
      st_next.pslverr = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
      st_reg.clk_out_oe_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign ext_flag_auto_clear = st_reg.ext_clr;
  assign rx_baud_tick = st_reg.rx_tick;
  assign tx_baud_tick = st_reg.tx_tick;
  assign clock_out_pin = st_reg.clk_out;
  assign clock_out_oe_n = st_reg.clk_out_oe_n;
  assign irq = st_reg.irq;
endmodule

// *** sim/tcru_assertions.sv ***
`timescale 1ns/1ps
`include "tcru_params.svh"
module tcru_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic trigger_pin,
  input wire logic count_input_pin,
  input wire logic timer1_overflow,
  input wire logic [3:0] ext_isr_entry,
  input wire logic [3:0] ext_flag_auto_clear,
  input wire logic rx_baud_tick,
  input wire logic tx_baud_tick,
  input wire logic clock_out_pin,
  input wire logic clock_out_oe_n,
  input wire logic irq
);
  // Shadow of software-only bits, rebuilt from completed writes
  logic wr_go;
  logic rsel, tsel, coe;
  logic [3:0] hc;
  logic [1:0] msk;
  assign wr_go = psel && penable && pready && pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsel <= 1'b0;
      tsel <= 1'b0;
      coe <= 1'b0;
      hc <= 4'h0;
      msk <= 2'h0;
    end else if (wr_go && paddr[11:2] == `TCRU_IDX_TIMER_CONTROL) begin
      rsel <= pwdata[`TCRU_CTL_RX_BAUD_SEL];
      tsel <= pwdata[`TCRU_CTL_TX_BAUD_SEL];
    end else if (wr_go && paddr[11:2] == `TCRU_IDX_TIMER_MODE_CONTROL) begin
      hc <= pwdata[7:4];
      coe <= pwdata[`TCRU_MOD_CLOCK_OUT_ENABLE];
    end else if (wr_go && paddr[11:2] == `TCRU_IDX_IRQ_MASK) begin
      msk <= pwdata[1:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_apb_ready; psel && !penable |=> pready; endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("pready missing after setup");
  property p_unmapped; pready && paddr[11:2] == 10'h3ff |-> pslverr && prdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_rx_t1; !rsel && timer1_overflow |=> rx_baud_tick; endproperty
  a_rx_t1: assert property (p_rx_t1) else $error("rx tick missing after timer1 overflow");
  property p_rx_src; rx_baud_tick |-> $past(timer1_overflow) || $past(rsel) || $past(rsel, 2); endproperty
  a_rx_src: assert property (p_rx_src) else $error("rx tick without source");
  property p_tx_t1; !tsel && timer1_overflow |=> tx_baud_tick; endproperty
  a_tx_t1: assert property (p_tx_t1) else $error("tx tick missing after timer1 overflow");
  property p_tx_src; tx_baud_tick |-> $past(timer1_overflow) || $past(tsel) || $past(tsel, 2); endproperty
  a_tx_src: assert property (p_tx_src) else $error("tx tick without source");
  property p_oe_off; clock_out_oe_n |-> !clock_out_pin; endproperty
  a_oe_off: assert property (p_oe_off) else $error("clock out active while disabled");
  property p_oe; coe == $past(coe) && coe == $past(coe, 2) |-> clock_out_oe_n == !coe; endproperty
  a_oe: assert property (p_oe) else $error("clock out enable not followed");
  property p_clkout;
    tsel && !clock_out_oe_n && $past(!clock_out_oe_n) && $changed(clock_out_pin) |-> ##[0:2] tx_baud_tick;
  endproperty
  a_clkout: assert property (p_clkout) else $error("clock out toggled without overflow");
  property p_autoclr; ext_flag_auto_clear == ($past(ext_isr_entry) & $past(hc)); endproperty
  a_autoclr: assert property (p_autoclr) else $error("auto clear pulse wrong");
  property p_irq_mask; irq |-> msk != 2'h0 || $past(msk) != 2'h0; endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq while fully masked");
  c_baud: cover property (tx_baud_tick && tsel);
  c_autoclr: cover property (ext_flag_auto_clear != 4'h0);
  c_irq: cover property (irq);
  c_err: cover property (pready && pslverr);
endmodule

// *** sim/tb.sv ***
`timescale 1ns/1ps
`include "tcru_params.svh"
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, trigger_pin, count_input_pin, timer1_overflow;
  logic rx_baud_tick, tx_baud_tick, clock_out_pin, clock_out_oe_n, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] ext_isr_entry, ext_flag_auto_clear;
  int n_fail = 0;
  int checks = 0;
  localparam logic [11:0] A_CTL = {`TCRU_IDX_TIMER_CONTROL, 2'b00};
  localparam logic [11:0] A_MOD = {`TCRU_IDX_TIMER_MODE_CONTROL, 2'b00};
  localparam logic [11:0] A_CRL = {`TCRU_IDX_CAPTURE_RELOAD_LOW, 2'b00};
  localparam logic [11:0] A_CRH = {`TCRU_IDX_CAPTURE_RELOAD_HIGH, 2'b00};
  localparam logic [11:0] A_CL = {`TCRU_IDX_COUNT_LOW, 2'b00};
  localparam logic [11:0] A_CH = {`TCRU_IDX_COUNT_HIGH, 2'b00};
  localparam logic [11:0] A_TCK = {`TCRU_IDX_TICK_CONFIG, 2'b00};
  localparam logic [11:0] A_IST = {`TCRU_IDX_IRQ_STATUS, 2'b00};
  localparam logic [11:0] A_MSK = {`TCRU_IDX_IRQ_MASK, 2'b00};
  typedef struct {logic [11:0] a; logic [7:0] d; logic [7:0] x; logic e;} tcru_row_t;
  tcru_row_t rows [9] = '{'{A_CRL, 8'ha5, 8'ha5, 1'b0}, '{A_CRH, 8'h5a, 8'h5a, 1'b0},
    '{A_CL, 8'h12, 8'h12, 1'b0}, '{A_CH, 8'h34, 8'h34, 1'b0}, '{A_MOD, 8'hff, 8'hfb, 1'b0},
    '{A_MOD, 8'h00, 8'h00, 1'b0}, '{A_TCK, 8'h01, 8'h01, 1'b0}, '{A_MSK, 8'h03, 8'h03, 1'b0},
    '{12'hffc, 8'h77, 8'h00, 1'b1}};
  tcru_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trigger_pin(trigger_pin), .count_input_pin(count_input_pin), .timer1_overflow(timer1_overflow),
    .ext_isr_entry(ext_isr_entry), .ext_flag_auto_clear(ext_flag_auto_clear), .rx_baud_tick(rx_baud_tick),
    .tx_baud_tick(tx_baud_tick), .clock_out_pin(clock_out_pin), .clock_out_oe_n(clock_out_oe_n), .irq(irq));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Request held until the rising edge that samples pready high, then released there
  task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d, output logic [31:0] r,
                     output logic e);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      chk("pready", 1, 0);
      tally_and_finish();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(a, 1'b1, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] x);
    logic [31:0] r;
    logic e;
    apb(a, 1'b0, 8'h00, r, e);
    chk($sformatf("reg %h", a), {24'h0, x}, r);
  endtask
  task automatic trig;
    trigger_pin <= 1'b0;
    cyc(4);
    trigger_pin <= 1'b1;
    cyc(6);
  endtask
  initial begin
    logic [31:0] r;
    logic e;
    int n;
    {presetn, psel, penable, pwrite, paddr, pwdata, timer1_overflow, ext_isr_entry} = '0;
    trigger_pin = 1'b1;
    count_input_pin = 1'b1;
    cyc(6);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].a, 1'b1, rows[i].d, r, e);
      apb(rows[i].a, 1'b0, 8'h00, r, e);
      chk("read", {24'h0, rows[i].x}, r);
      chk("slverr", {31'h0, rows[i].e}, {31'h0, e});
    end
    $display("test registers finished");
    wr(A_CRL, 8'hf0);
    wr(A_CRH, 8'hff);
    wr(A_CL, 8'hfe);
    wr(A_CH, 8'hff);
    wr(A_CTL, 8'h04);
    for (n = 0; n < 80 && irq !== 1'b1; n++) @(negedge pclk);
    chk("irq ovf", 1, {31'h0, irq});
    wr(A_CTL, 8'h80);
    rd(A_CH, 8'hff);
    rd(A_CTL, 8'h80);
    apb(A_CL, 1'b0, 8'h00, r, e);
    cyc(20);
    rd(A_CL, r[7:0]);
    wr(A_IST, 8'h01);
    cyc(2);
    chk("irq clr", 0, {31'h0, irq});
    wr(A_CTL, 8'h40);
    cyc(2);
    chk("irq sw", 1, {31'h0, irq});
    wr(A_IST, 8'h03);
    $display("test reload finished");
    wr(A_CL, 8'h00);
    wr(A_CTL, 8'h06);
    repeat (5) begin
      count_input_pin <= 1'b0;
      cyc(3);
      count_input_pin <= 1'b1;
      cyc(3);
    end
    cyc(4);
    wr(A_CTL, 8'h00);
    rd(A_CL, 8'h05);
    wr(A_CL, 8'h34);
    wr(A_CH, 8'h12);
    wr(A_MOD, 8'h08);
    wr(A_CTL, 8'h09);
    trig();
    rd(A_CRL, 8'h34);
    rd(A_CRH, 8'h12);
    rd(A_CL, 8'h00);
    rd(A_CTL, 8'h49);
    wr(A_CTL, 8'h01);
    wr(A_CL, 8'h55);
    trig();
    rd(A_CRL, 8'h34);
    rd(A_CTL, 8'h01);
    wr(A_IST, 8'h03);
    $display("test capture finished");
    wr(A_CRL, 8'hf0);
    wr(A_CRH, 8'hff);
    wr(A_CL, 8'hf0);
    wr(A_CH, 8'hff);
    wr(A_MOD, 8'h02);
    wr(A_CTL, 8'h14);
    for (n = 0; n < 200 && tx_baud_tick !== 1'b1; n++) @(negedge pclk);
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (tx_baud_tick !== 1'b1 && n < 200);
    chk("baud gap", 32, n);
    @(posedge pclk);
    timer1_overflow <= 1'b1;
    @(posedge pclk);
    timer1_overflow <= 1'b0;
    @(negedge pclk);
    chk("rx t1", 1, {31'h0, rx_baud_tick});
    chk("oe on", 0, {31'h0, clock_out_oe_n});
    rd(A_CTL, 8'h14);
    wr(A_CTL, 8'h00);
    wr(A_MOD, 8'h00);
    cyc(3);
    chk("oe off", 1, {31'h0, clock_out_oe_n});
    $display("test baud finished");
    for (int k = 0; k < 2; k++) begin
      wr(A_MOD, k == 0 ? 8'hf0 : 8'h00);
      ext_isr_entry <= 4'b0101;
      @(posedge pclk);
      ext_isr_entry <= 4'b0000;
      @(negedge pclk);
      chk("auto clear", k == 0 ? 32'h5 : 32'h0, {28'h0, ext_flag_auto_clear});
    end
    // Pin low selects down counting; trigger edge ignored with trigger enable clear
    trigger_pin <= 1'b0;
    wr(A_CRL, 8'h00);
    wr(A_CRH, 8'h00);
    wr(A_CL, 8'h02);
    wr(A_CH, 8'h00);
    wr(A_MOD, 8'h01);
    wr(A_CTL, 8'h04);
    for (n = 0; n < 80 && irq !== 1'b1; n++) @(negedge pclk);
    chk("irq down", 1, {31'h0, irq});
    rd(A_CTL, 8'hc4);
    wr(A_CTL, 8'h00);
    rd(A_CH, 8'hff);
    wr(A_MOD, 8'h00);
    trigger_pin <= 1'b1;
    cyc(6);
    $display("test down count finished");
    wr(A_CTL, 8'h04);
    cyc(3);
    presetn <= 1'b0;
    cyc(2);
    presetn <= 1'b1;
    foreach (rows[i]) rd(rows[i].a, 8'h00);
    chk("oe reset", 1, {31'h0, clock_out_oe_n});
    $display("test reset finished");
    tally_and_finish();
  end
  initial begin
    repeat (40000) @(posedge pclk);
    chk("run", 1, 0);
    tally_and_finish();
  end
endmodule
bind tcru_top tcru_assertions chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .trigger_pin(trigger_pin), .count_input_pin(count_input_pin), .timer1_overflow(timer1_overflow),
  .ext_isr_entry(ext_isr_entry), .ext_flag_auto_clear(ext_flag_auto_clear), .rx_baud_tick(rx_baud_tick),
  .tx_baud_tick(tx_baud_tick), .clock_out_pin(clock_out_pin), .clock_out_oe_n(clock_out_oe_n), .irq(irq));
